// ---- core/disk_control_operation_sequencer.sv ----
`timescale 1ns/1ps
// Overview of operation
// R1: Host phase one is idle and takes the first op code byte.
// R2: Idle with nothing requested, a set seek-complete flag raises service request.
// R3: Op code bytes two, three and three file address bytes, one per phase.
// R4: Three reference address bytes are taken, then the phase reaches dispatch.
// R5: Taking the first reference byte out of step sets the out-of-step flag.
// R6: Dispatch with a pause request loads the drive phase with pause.
// R7: Dispatch, non-pause, controller in local forces the first result-return phase.
// R8: Dispatch, test, controller remote loads the drive phase with test.
// R9: Dispatch, read, controller remote loads the drive phase with read.
// R10: Dispatch, write, controller remote loads the drive phase with write.
// R11: Reference address is returned in three bytes before each buffer exchange.
// R12: Write fill takes 60 transfers; full or terminate returns to reference input.
// R13: In a read, the write-fill phase only advances to read-data output.
// R14: Read-data output moves read buffer bytes; count depends on variants.
// R15: Six result-return bytes are sent, then channel clears and phase returns to zero.
// R16: Drive phase one-hot code 00001 is its idle state.
// R17: Pause runs a delay of PAUSE_US microseconds, then idles and forces result return.
// R18: Test sends the test operator; its result descriptor ends it.
// R19: Read sends op code and file address, again after seek, then awaits data.
// R20: A needed seek brings a two-byte result; go to result return and idle.
// R21: A full read buffer advances to reference return and requests service.
// R22: Read data arrives as 16-bit words and is packed into 24-bit words.
// R23: Terminate sets a flag, drops select; the descriptor ends the operation.
// R24: Pause length is a parameter in microseconds counted on the timing bus.
module disk_control_operation_sequencer #(
	parameter int PAUSE_US = seq_pkg::PAUSE_US_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire seq_pkg::host_byte_s host_in,
	output seq_pkg::host_byte_s host_out,
	input wire logic host_step,
	input wire logic host_out_of_step,
	input wire logic host_terminate,
	input wire logic margin_variant,
	input wire logic ecc_variant,
	input wire logic microsecond_timing_bus,
	input wire logic controller_local,
	input wire logic seek_complete_flag,
	input wire logic read_buffer_full,
	input wire logic seek_needed,
	input wire logic [15:0] drive_word,
	input wire logic drive_word_strobe,
	input wire logic drive_result_strobe,
	output logic [15:0] drive_info,
	output logic drive_send,
	output logic drive_select,
	output logic drive_execute,
	output logic [23:0] read_pack_word,
	output logic read_pack_valid,
	output logic [5:0] write_fill_count,
	output logic [4:0] host_phase_counter,
	output logic [4:0] drive_phase_counter,
	output logic service_request_line,
	output logic out_of_step_flag,
	output logic terminate_flag,
	output logic channel_clear
);
	import seq_pkg::*;

	logic [4:0] hp_q;
	drive_phase_e dp_q;
	logic [23:0] op_q;
	logic [23:0] file_q;
	logic [23:0] ref_q;
	logic [15:0] result_q;
	logic [1:0] op_kind;
	logic [7:0] rd_count_q;
	logic [7:0] rd_limit;
	logic [31:0] pause_q;
	logic [1:0] init_q;
	logic seek_wait_q;
	logic result_half_q;
	logic [2:0] pack_q;
	logic [23:0] pack_hold_q;
	logic take;

	assign op_kind = op_q[OP_FIELD_LSB +: 2];
	assign take = host_step && host_in.valid;
	assign host_phase_counter = hp_q;
	assign drive_phase_counter = dp_q;
	assign drive_execute = (dp_q == DP_READ) && !read_buffer_full && hp_q == HP_DISPATCH && init_q == 2'h2 && !drive_send;

	always_comb begin
		rd_limit = STD_READ_CHARS;
		if (ecc_variant) begin
			rd_limit = ECC_READ_CHARS;
		end else if (margin_variant) begin
			rd_limit = MARGIN_READ_CHARS;
		end
	end

	// Host phase sequencing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hp_q <= HP_CLEAR;
		end else if (dp_q == DP_PAUSE && pause_q == 32'h0000_0001 && microsecond_timing_bus) begin
			// R17: pause done
			hp_q <= HP_RESULT0;
		end else if ((dp_q == DP_TEST || dp_q == DP_READ || dp_q == DP_WRITE) && drive_result_strobe
				&& result_half_q) begin
			// R18: R20: R23: descriptor ends drive flow
			hp_q <= HP_RESULT0;
		end else if (hp_q == HP_CLEAR) begin
			hp_q <= HP_IDLE;
		end else if (hp_q == HP_DISPATCH) begin
			if (op_kind != OP_PAUSE && controller_local) begin
				// R7: local forces result
				hp_q <= HP_RESULT0;
			end else if (dp_q == DP_READ && read_buffer_full) begin
				// R21: buffer full
				hp_q <= HP_REF_OUT0;
			end else if (dp_q == DP_WRITE && init_q == 2'h2 && !seek_wait_q) begin
				hp_q <= HP_REF_OUT0;
			end
		end else if (hp_q == HP_WBUF_FILL) begin
			if (op_kind == OP_READ) begin
				// R13: skip fill in read
				hp_q <= HP_RDATA_OUT;
			end else if (host_terminate || (take && write_fill_count == WRITE_XFERS - 6'h01)) begin
				// R12: full or terminate
				hp_q <= HP_REF_IN0;
			end
		end else if (hp_q == HP_RDATA_OUT) begin
			// R14: read data out
			if (take && rd_count_q == rd_limit - 8'h01) begin
				hp_q <= HP_DISPATCH;
			end
		end else if (hp_q == HP_RESULT_LAST) begin
			// R15: clear channel
			if (take) begin
				hp_q <= HP_CLEAR;
			end
		end else if (take) begin
			// R1: R3: R4: R11: one byte per phase
			hp_q <= hp_q + 5'h01;
		end
	end

	assign channel_clear = (hp_q == HP_RESULT_LAST) && take;

	// Bytes taken from the host
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			op_q <= 24'h00_0000;
			file_q <= 24'h00_0000;
			ref_q <= 24'h00_0000;
		end else if (take) begin
			if (hp_q >= HP_IDLE && hp_q < 5'h04) begin
				op_q <= {op_q[15:0], host_in.data};
			end else if (hp_q >= 5'h04 && hp_q < HP_REF_IN0) begin
				file_q <= {file_q[15:0], host_in.data};
			end else if (hp_q >= HP_REF_IN0 && hp_q < HP_DISPATCH) begin
				ref_q <= {ref_q[15:0], host_in.data};
			end
		end
	end

	// Bytes returned to the host
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			host_out <= '0;
		end else begin
			host_out.valid <= 1'b0;
			if ((hp_q >= HP_REF_OUT0 && hp_q <= HP_REF_OUT2) || (hp_q >= HP_RESULT0 && hp_q < 5'h15)) begin
				host_out.valid <= host_step;
				host_out.data <= ref_q[8'(5'h02 - (hp_q >= HP_RESULT0 ? hp_q - HP_RESULT0 : hp_q - HP_REF_OUT0)) * 8 +: 8];
			end else if (hp_q >= 5'h15 && hp_q <= HP_RESULT_LAST) begin
				host_out.valid <= host_step;
				host_out.data <= (hp_q == 5'h15) ? result_q[15:8] : (hp_q == 5'h16) ? result_q[7:0]
					: {6'h00, out_of_step_flag, terminate_flag};
			end else if (hp_q == HP_RDATA_OUT) begin
				host_out.valid <= host_step;
				host_out.data <= read_pack_word[7:0];
			end
		end
	end

	// Drive phase sequencing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			// R16: idle at reset
			dp_q <= DP_IDLE;
		end else begin
			case (dp_q)
				DP_IDLE: begin
					if (hp_q == HP_DISPATCH) begin
						if (op_kind == OP_PAUSE) begin
							// R6: pause
							dp_q <= DP_PAUSE;
						end else if (!controller_local && op_kind == OP_TEST) begin
							// R8: test
							dp_q <= DP_TEST;
						end else if (!controller_local && op_kind == OP_READ) begin
							// R9: read
							dp_q <= DP_READ;
						end else if (!controller_local && op_kind == OP_WRITE) begin
							// R10: write, remote taken
							dp_q <= DP_WRITE;
						end
					end
				end
				DP_PAUSE: begin
					if (pause_q == 32'h0000_0001 && microsecond_timing_bus) begin
						dp_q <= DP_IDLE;
					end
				end
				default: begin
					if (drive_result_strobe && result_half_q) begin
						dp_q <= DP_IDLE;
					end
				end
			endcase
		end
	end

	// R24: pause delay in microseconds
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pause_q <= 32'h0000_0000;
		end else if (dp_q != DP_PAUSE) begin
			pause_q <= 32'(PAUSE_US);
		end else if (microsecond_timing_bus && pause_q != 32'h0000_0000) begin
			pause_q <= pause_q - 32'h0000_0001;
		end
	end

	// R19: initiate words, resent after seek
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			init_q <= 2'h0;
			seek_wait_q <= 1'b0;
			drive_send <= 1'b0;
			drive_info <= 16'h0000;
		end else if (dp_q == DP_IDLE || dp_q == DP_PAUSE) begin
			init_q <= 2'h0;
			seek_wait_q <= 1'b0;
			drive_send <= 1'b0;
		end else if (init_q == 2'h0) begin
			drive_send <= 1'b1;
			drive_info <= dp_q == DP_TEST ? {op_q[23:16], 8'h00} : {op_q[23:16], file_q[23:16]};
			init_q <= 2'h1;
		end else if (init_q == 2'h1 && drive_word_strobe) begin
			drive_info <= file_q[15:0];
			init_q <= 2'h2;
		end else if (init_q == 2'h2 && drive_word_strobe && drive_send) begin
			drive_send <= 1'b0;
			seek_wait_q <= seek_needed;
		end else if (seek_wait_q && seek_complete_flag) begin
			init_q <= 2'h0;
			seek_wait_q <= 1'b0;
		end
	end

	// R23: terminate drops select
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			terminate_flag <= 1'b0;
			drive_select <= 1'b0;
		end else begin
			if (host_terminate && dp_q != DP_IDLE) begin
				terminate_flag <= 1'b1;
			end else if (hp_q == HP_IDLE) begin
				terminate_flag <= 1'b0;
			end
			drive_select <= (dp_q == DP_TEST || dp_q == DP_READ || dp_q == DP_WRITE)
				&& !terminate_flag && !host_terminate && !seek_wait_q;
		end
	end

	// Two-byte descriptor from the drive side
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_q <= 16'h0000;
			result_half_q <= 1'b0;
		end else if (dp_q == DP_IDLE) begin
			result_half_q <= 1'b0;
		end else if (drive_result_strobe) begin
			result_q <= {result_q[7:0], drive_word[7:0]};
			result_half_q <= !result_half_q;
		end
	end

	// R2: R21: R5: service and step flags; set wins over clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			service_request_line <= 1'b0;
			out_of_step_flag <= 1'b0;
		end else begin
			if ((hp_q == HP_IDLE && !take && seek_complete_flag)
					|| (hp_q == HP_DISPATCH && dp_q == DP_READ && read_buffer_full)) begin
				service_request_line <= 1'b1;
			end else if (take) begin
				service_request_line <= 1'b0;
			end
			if (hp_q == HP_REF_IN0 && take && host_out_of_step) begin
				out_of_step_flag <= 1'b1;
			end else if (hp_q == HP_CLEAR) begin
				out_of_step_flag <= 1'b0;
			end
		end
	end

	// Write fill and read output counts
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			write_fill_count <= 6'h00;
			rd_count_q <= 8'h00;
		end else begin
			if (hp_q != HP_WBUF_FILL) begin
				write_fill_count <= 6'h00;
			end else if (take) begin
				write_fill_count <= write_fill_count + 6'h01;
			end
			if (hp_q != HP_RDATA_OUT) begin
				rd_count_q <= 8'h00;
			end else if (take) begin
				rd_count_q <= rd_count_q + 8'h01;
			end
		end
	end

	// R22: pack 16-bit words into 24-bit words
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pack_q <= 3'h0;
			pack_hold_q <= 24'h00_0000;
			read_pack_word <= 24'h00_0000;
			read_pack_valid <= 1'b0;
		end else begin
			read_pack_valid <= 1'b0;
			if (dp_q != DP_READ) begin
				pack_q <= 3'h0;
			end else if (drive_word_strobe && drive_execute) begin
				case (pack_q)
					3'h0: begin
						pack_hold_q <= {drive_word, 8'h00};
						pack_q <= 3'h1;
					end
					3'h1: begin
						read_pack_word <= {pack_hold_q[23:8], drive_word[15:8]};
						read_pack_valid <= 1'b1;
						pack_hold_q <= {drive_word[7:0], 16'h0000};
						pack_q <= PACK_STEP_LAST;
					end
					default: begin
						read_pack_word <= {pack_hold_q[23:16], drive_word};
						read_pack_valid <= 1'b1;
						pack_q <= 3'h0;
					end
				endcase
			end
		end
	end
endmodule

// ---- core/seq_pkg.sv ----
package seq_pkg;
	localparam int PHASE_W = 5;
	localparam logic [4:0] HP_CLEAR = 5'h00;
	localparam logic [4:0] HP_IDLE = 5'h01;
	localparam logic [4:0] HP_REF_IN0 = 5'h07;
	localparam logic [4:0] HP_DISPATCH = 5'h0A;
	localparam logic [4:0] HP_REF_OUT0 = 5'h0B;
	localparam logic [4:0] HP_REF_OUT2 = 5'h0D;
	localparam logic [4:0] HP_WBUF_FILL = 5'h0E;
	localparam logic [4:0] HP_RDATA_OUT = 5'h0F;
	localparam logic [4:0] HP_RESULT0 = 5'h12;
	localparam logic [4:0] HP_RESULT_LAST = 5'h17;
	localparam logic [1:0] OP_PAUSE = 2'h0;
	localparam logic [1:0] OP_TEST = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h3;
	localparam int OP_FIELD_LSB = 22;
	localparam logic [5:0] WRITE_XFERS = 6'h3C;
	localparam logic [7:0] STD_READ_CHARS = 8'hBA;
	localparam logic [7:0] ECC_READ_CHARS = 8'hBE;
	localparam logic [7:0] MARGIN_READ_CHARS = 8'h5D;
	localparam int CLK_MHZ = 200;
	localparam int PAUSE_US_DEFAULT = 1000;
	localparam logic [2:0] PACK_STEP_LAST = 3'h2;

	typedef enum logic [4:0] {
		DP_IDLE = 5'b00001,
		DP_PAUSE = 5'b00010,
		DP_TEST = 5'b00100,
		DP_READ = 5'b01000,
		DP_WRITE = 5'b10000
	} drive_phase_e;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} host_byte_s;
endpackage

// ---- dv/drive_model.sv ----
`timescale 1ns/1ps
module drive_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic drive_send,
	input wire logic drive_select,
	input wire logic drive_execute,
	input wire logic seek_mode,
	input wire logic finish,
	output logic [15:0] drive_word,
	output logic drive_word_strobe,
	output logic drive_result_strobe,
	output logic seek_needed
);
	// Slow answers: two idle cycles before every strobe
	task automatic pulse(input logic res);
		repeat (2) @(negedge clk);
		drive_word_strobe = !res;
		drive_result_strobe = res;
		drive_word = drive_word + 16'h0101;
		@(negedge clk);
		{drive_word_strobe, drive_result_strobe} = 2'h0;
		drive_word = ~drive_word;
	endtask
	initial begin
		{drive_word, drive_word_strobe, drive_result_strobe, seek_needed} = '0;
	end
	always begin
		@(negedge clk iff (drive_send && !reset));
		seek_needed = seek_mode;
		pulse(1'h0);
		pulse(1'h0);
		while (drive_select && !finish && !reset) begin
			if (drive_execute) pulse(1'h0);
			else @(negedge clk);
		end
		if (!reset) begin
			pulse(1'h1);
			pulse(1'h1);
		end
	end
endmodule

// ---- dv/seq_sva.sv ----
`timescale 1ns/1ps
module seq_sva #(
	parameter int PAUSE_US = 3
) (
	input wire logic clk,
	input wire logic reset,
	input wire seq_pkg::host_byte_s host_in,
	input wire seq_pkg::host_byte_s host_out,
	input wire logic host_step,
	input wire logic microsecond_timing_bus,
	input wire logic controller_local,
	input wire logic drive_result_strobe,
	input wire logic [4:0] host_phase_counter,
	input wire logic [4:0] drive_phase_counter
);
	import seq_pkg::*;
	logic [1:0] op_q, res_q;
	int ticks_q;
	logic take, at_disp;
	logic [4:0] exp_dp;
	assign take = host_step && host_in.valid;
	assign at_disp = host_phase_counter == HP_DISPATCH && drive_phase_counter == DP_IDLE;
	assign exp_dp = op_q == OP_TEST ? DP_TEST : (op_q == OP_READ ? DP_READ : DP_WRITE);
	// Op kind sits in the top bits of the first byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			op_q <= 2'h0;
			res_q <= 2'h0;
			ticks_q <= 0;
		end else begin
			if (take && host_phase_counter == HP_IDLE) begin
				op_q <= host_in.data[7:6];
			end
			res_q <= drive_phase_counter == DP_IDLE ? 2'h0 : res_q + 2'(drive_result_strobe);
			ticks_q <= drive_phase_counter != DP_PAUSE ? 0 : ticks_q + int'(microsecond_timing_bus);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	chk_phase_take: assert property (take && host_phase_counter inside {[HP_IDLE:5'h09]}
		|=> host_phase_counter == $past(host_phase_counter) + 5'h01) else $error("input phase stuck");
	chk_zero_idle: assert property (host_phase_counter == HP_CLEAR |=> host_phase_counter == HP_IDLE)
		else $error("zero phase stuck");
	chk_pause_load: assert property (at_disp && op_q == OP_PAUSE |-> ##[1:3] drive_phase_counter == DP_PAUSE)
		else $error("pause not loaded");
	chk_local_result: assert property (at_disp && op_q != OP_PAUSE && controller_local
		|-> ##[1:3] host_phase_counter == HP_RESULT0) else $error("local not forced");
	chk_remote_load: assert property (at_disp && op_q != OP_PAUSE && !controller_local
		|-> ##[1:3] drive_phase_counter == exp_dp) else $error("wrong drive phase");
	chk_pause_end: assert property ($fell(drive_phase_counter == DP_PAUSE)
		|-> host_phase_counter == HP_RESULT0 && ticks_q inside {[PAUSE_US - 1:PAUSE_US]}) else $error("pause end");
	chk_result_end: assert property (drive_result_strobe && res_q == 2'h1 && drive_phase_counter != DP_IDLE
		|-> ##[1:2] (host_phase_counter == HP_RESULT0 && drive_phase_counter == DP_IDLE)) else $error("no end");
	chk_ret_valid: assert property (host_step && host_phase_counter inside {[HP_REF_OUT0:HP_REF_OUT2],
		[HP_RESULT0:HP_RESULT_LAST]} |=> host_out.valid) else $error("no return byte");
	cover property ($fell(drive_phase_counter == DP_PAUSE));
	cover property (drive_result_strobe && res_q == 2'h1);
	cover property (host_phase_counter == HP_RESULT_LAST && host_step);
endmodule
bind disk_control_operation_sequencer seq_sva #(.PAUSE_US(PAUSE_US)) u_sva (.*);

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import seq_pkg::*;
	localparam int PUS = 3;
	typedef struct packed {logic [1:0] op; logic loc; logic [4:0] dp;} row_s;
	row_s rows [8] = '{'{OP_PAUSE, 1'h0, DP_PAUSE}, '{OP_PAUSE, 1'h1, DP_PAUSE}, '{OP_TEST, 1'h1, DP_IDLE},
		'{OP_READ, 1'h1, DP_IDLE}, '{OP_WRITE, 1'h1, DP_IDLE}, '{OP_TEST, 1'h0, DP_TEST},
		'{OP_READ, 1'h0, DP_READ}, '{OP_WRITE, 1'h0, DP_WRITE}};
	logic clk, reset, host_step, host_out_of_step, host_terminate, microsecond_timing_bus, controller_local;
	logic seek_complete_flag, read_buffer_full, seek_needed, drive_word_strobe, drive_result_strobe, drive_send;
	logic drive_select, drive_execute, read_pack_valid, service_request_line, out_of_step_flag, terminate_flag;
	logic channel_clear, seek_mode, finish, ov;
	logic [15:0] drive_word, drive_info;
	logic [23:0] read_pack_word;
	logic [5:0] write_fill_count;
	logic [4:0] host_phase_counter, drive_phase_counter;
	host_byte_s host_in, host_out;
	int errors, comparisons, packs, n, us;
	disk_control_operation_sequencer #(.PAUSE_US(PUS)) dut (.*, .margin_variant(1'h0), .ecc_variant(1'h0));
	drive_model drv (.*);
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk) begin
		us <= us == CLK_MHZ - 1 ? 0 : us + 1;
		microsecond_timing_bus <= us == CLK_MHZ - 1;
	end
	always @(posedge clk) begin
		if (read_pack_valid === 1'h1) packs++;
	end
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'h1) begin
			errors++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	task automatic step(input logic v, input logic [7:0] b);
		@(negedge clk);
		host_step = 1'h1;
		host_in = '{v, b};
		@(negedge clk);
		host_step = 1'h0;
		host_in.valid = 1'h0;
		ov = host_out.valid;
	endtask
	task automatic send_op(input logic [1:0] op);
		step(1'h1, {op, 6'h00});
		for (int i = 1; i < 9; i++) step(1'h1, 8'(i));
	endtask
	task automatic wait_phase(input logic [4:0] p);
		for (n = 0; n < 4000 && host_phase_counter !== p; n++) @(negedge clk);
		check(host_phase_counter === p, "phase not reached");
	endtask
	task automatic return_bytes(input int cnt);
		repeat (cnt) begin
			step(1'h1, 8'h00);
			check(ov === 1'h1, "no return byte");
		end
	endtask
	task automatic do_reset;
		reset = 1'h1;
		packs = 0;
		repeat (10) @(negedge clk);
		reset = 1'h0;
	endtask
	task automatic final_report;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{reset, host_step, host_out_of_step, host_terminate, microsecond_timing_bus} = 5'h10;
		{controller_local, seek_complete_flag, read_buffer_full, seek_mode, finish} = 5'h00;
		host_in = '0;
		{errors, comparisons, packs, us} = '0;
		repeat (10) @(negedge clk);
		check(drive_phase_counter === DP_IDLE && host_phase_counter === HP_CLEAR, "reset state");
		reset = 1'h0;
		seek_complete_flag = 1'h1;
		repeat (4) @(negedge clk);
		check(service_request_line === 1'h1, "no service request");
		seek_complete_flag = 1'h0;
		$display("test idle done");
		foreach (rows[i]) begin
			do_reset();
			controller_local = rows[i].loc;
			send_op(rows[i].op);
			repeat (3) @(negedge clk);
			check(drive_phase_counter === rows[i].dp, "dispatch");
			if (rows[i].dp === DP_IDLE) check(host_phase_counter === HP_RESULT0, "local");
		end
		controller_local = 1'h0;
		$display("test dispatch done");
		do_reset();
		send_op(OP_PAUSE);
		wait_phase(HP_RESULT0);
		check(n >= (PUS - 1) * CLK_MHZ && n <= (PUS + 1) * CLK_MHZ, "pause length");
		check(drive_phase_counter === DP_IDLE, "pause idle");
		return_bytes(5);
		@(negedge clk);
		host_step = 1'h1;
		host_in.valid = 1'h1;
		#1;
		check(channel_clear === 1'h1, "no channel clear");
		@(negedge clk);
		host_step = 1'h0;
		host_in.valid = 1'h0;
		@(negedge clk);
		check(host_phase_counter === HP_IDLE, "no wrap");
		$display("test pause done");
		for (int k = 0; k < 2; k++) begin
			do_reset();
			finish = k == 0;
			seek_mode = k == 1;
			send_op(k == 0 ? OP_TEST : OP_READ);
			wait_phase(HP_RESULT0);
			check(drive_phase_counter === DP_IDLE, "result idle");
		end
		{finish, seek_mode} = 2'h0;
		$display("test result done");
		do_reset();
		host_out_of_step = 1'h1;
		send_op(OP_WRITE);
		host_out_of_step = 1'h0;
		check(out_of_step_flag === 1'h1, "out of step");
		wait_phase(HP_REF_OUT0);
		return_bytes(3);
		repeat (59) step(1'h1, 8'h5A);
		check(write_fill_count === 6'h3B, "fill count");
		check(host_phase_counter === HP_WBUF_FILL, "early full");
		step(1'h1, 8'hA5);
		check(host_phase_counter === HP_REF_IN0, "write full");
		$display("test write done");
		do_reset();
		send_op(OP_READ);
		for (n = 0; n < 4000 && packs < 2; n++) @(negedge clk);
		check(packs >= 2, "no packing");
		read_buffer_full = 1'h1;
		wait_phase(HP_REF_OUT0);
		check(service_request_line === 1'h1 && drive_phase_counter === DP_READ, "read full");
		read_buffer_full = 1'h0;
		return_bytes(3);
		wait_phase(HP_RDATA_OUT);
		step(1'h0, 8'h00);
		check(ov === 1'h1, "read data");
		host_terminate = 1'h1;
		repeat (3) @(negedge clk);
		check(terminate_flag === 1'h1 && drive_select === 1'h0, "terminate");
		wait_phase(HP_RESULT0);
		host_terminate = 1'h0;
		check(drive_phase_counter === DP_IDLE, "term idle");
		$display("test read done");
		final_report();
	end
	initial begin
		#300000;
		errors++;
		$display("ERROR %0t watchdog expired", $time);
		final_report();
	end
endmodule
